// file: hw/pbs_pkg.sv
// package for the pin boundary-scan cell block
package pbs_pkg;
  // port pin count and chain layout
  localparam int PORT_W = 8;
  // cell indices in the chain, tdo side first
  localparam int CELL_RST   = 0;
  localparam int CELL_SCLOE = 1;
  localparam int CELL_SCLIN = 2;
  localparam int CELL_SDAOE = 3;
  localparam int CELL_SDAIN = 4;
  localparam int CELL_XOEN  = 5;
  localparam int CELL_XOUT  = 6;
  localparam int CELL_TOEN  = 7;
  localparam int CELL_TOUT  = 8;
  localparam int CELL_PORT0 = 9;
  localparam int CELLS_PER_PIN = 3;
  localparam int CHAIN_LEN = CELL_PORT0 + CELLS_PER_PIN * PORT_W;
  // per-pin offsets inside a port group
  localparam int PIN_ID = 0;
  localparam int PIN_OD = 1;
  localparam int PIN_OC = 2;

  // link-side controls from the test access port controller
  typedef struct packed {
    logic mode;
    logic capture;
    logic shift;
    logic update;
    logic tdi;
  } pbs_tap_t;

  // reset sources seen by the observe-only reset cell
  typedef struct packed {
    logic cpu_reset_request_n;
    logic cpu_reset_enable;
    logic general_reset_n;
    logic power_on_reset;
    logic config_download;
  } pbs_rst_src_t;

  // link clock edge detector states
  typedef enum logic [1:0] {
    PBS_LOW  = 2'b00,
    PBS_RISE = 2'b01,
    PBS_HIGH = 2'b11,
    PBS_FALL = 2'b10
  } pbs_edge_t;
endpackage : pbs_pkg

// file: hw/pbs_scan_cells.sv
// boundary-scan cells for the processor-side pins
//
// Behaviour
// - A plain port pin captures the pin input register (pin level in test mode), drives from the port output register and enables from the data direction bit.
// - Pull-up disable equals data direction bit OR NOT port output bit.
// - Alternate functions sit outside the cells so test-mode capture sees the real pin level.
// - The reset pin is not scanned; the internal processor reset is captured by an observe-only cell.
// - The observed reset is high when the enabled reset request is low, general reset is active, power-on reset is active, or configuration loads.
// - Each two-wire pin has an active-high output enable in a general cell that pulls the pin low.
// - Two-wire data and clock in bits are observe-only cells.
// - Each external oscillator has an enable in a general cell and its output in an observe-only cell.
// - The timer oscillator is scanned the same way as the main oscillator.
// - The internal RC oscillator is not in the chain.
`timescale 1ns/1ps
`default_nettype none
module pbs_scan_cells
  import pbs_pkg::*;
(
  input  wire logic                CLK_SYS,
  input  wire logic                RST,
  input  wire logic                TCK,
  input  wire pbs_tap_t            TAP,
  output logic                     TDO,
  input  wire pbs_rst_src_t        RST_SRC,
  output logic                     CPU_RESET_OBS,
  input  wire logic [PORT_W-1:0]   PIN_INPUT_REGISTER,
  input  wire logic [PORT_W-1:0]   PORT_OUTPUT_REGISTER,
  input  wire logic [PORT_W-1:0]   DATA_DIRECTION_BIT,
  input  wire logic [PORT_W-1:0]   PIN_LEVEL,
  input  wire logic [PORT_W-1:0]   FUNC_OUT,
  input  wire logic [PORT_W-1:0]   FUNC_OE,
  output logic      [PORT_W-1:0]   PIN_OUT,
  output logic      [PORT_W-1:0]   PIN_OE,
  output logic      [PORT_W-1:0]   PULLUP_DISABLE,
  input  wire logic                SCL_IN,
  input  wire logic                SDA_IN,
  input  wire logic                SCL_FUNC_OE,
  input  wire logic                SDA_FUNC_OE,
  output logic                     SCL_OUT,
  output logic                     SCL_OE,
  output logic                     SDA_OUT,
  output logic                     SDA_OE,
  input  wire logic                XTAL_EN_FUNC,
  input  wire logic                XTAL_CLK,
  output logic                     XTAL_EN,
  input  wire logic                TOSC_EN_FUNC,
  input  wire logic                TOSC_CLK,
  output logic                     TOSC_EN
);

  // ************************************************************
  // link input synchronisers
  // ************************************************************
  // test port and pad level flops
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] sync1_nxt;
  logic [PORT_W-1:0] pin_s1_r;
  logic [PORT_W-1:0] pin_s2_r;

  // two flops for every foreign input
  always_comb begin
    sync1_nxt = {TCK, TAP};
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sync1_r  <= '0;
      sync2_r  <= '0;
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      sync1_r  <= sync1_nxt;
      sync2_r  <= sync1_r;
      pin_s1_r <= PIN_LEVEL;
      pin_s2_r <= pin_s1_r;
    end
  end

  // synchronised test clock and controls
  logic     tck_s;
  pbs_tap_t tap_s;
  assign tck_s = sync2_r[5];
  assign tap_s = sync2_r[4:0];

  // ************************************************************
  // observed pad synchronisers
  // ************************************************************
  logic [3:0] pad_s1_r;
  logic [3:0] pad_s2_r;
  logic [3:0] pad_s1_nxt;
  logic [3:0] pad_s2_nxt;
  logic       scl_in_s;
  logic       sda_in_s;
  logic       xtal_clk_s;
  logic       tosc_clk_s;

  // observe-only pads come from outside the clock domain
  always_comb begin
    pad_s1_nxt = {TOSC_CLK, XTAL_CLK, SDA_IN, SCL_IN};
    pad_s2_nxt = pad_s1_r;
  end

  // second stage is the only reader of the first
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pad_s1_r <= '0;
      pad_s2_r <= '0;
    end else begin
      pad_s1_r <= pad_s1_nxt;
      pad_s2_r <= pad_s2_nxt;
    end
  end

  // named views of the synchronised pads
  assign scl_in_s   = pad_s2_r[0];
  assign sda_in_s   = pad_s2_r[1];
  assign xtal_clk_s = pad_s2_r[2];
  assign tosc_clk_s = pad_s2_r[3];

  // ************************************************************
  // test clock edge finder
  // ************************************************************
  // edge finder state
  pbs_edge_t edge_r;
  pbs_edge_t edge_nxt;

  // gray walk low, rise, high, fall
  always_comb begin
    case (edge_r)
      PBS_LOW:  edge_nxt = tck_s ? PBS_RISE : PBS_LOW;
      PBS_RISE: edge_nxt = tck_s ? PBS_HIGH : PBS_FALL;
      PBS_HIGH: edge_nxt = tck_s ? PBS_HIGH : PBS_FALL;
      PBS_FALL: edge_nxt = tck_s ? PBS_RISE : PBS_LOW;
      default:  edge_nxt = PBS_LOW;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      edge_r <= PBS_LOW;
    end else begin
      edge_r <= edge_nxt;
    end
  end

  // one-cycle strobes per test clock edge
  logic tck_rise;
  logic tck_fall;
  assign tck_rise = (edge_r == PBS_RISE);
  assign tck_fall = (edge_r == PBS_FALL);

  // ************************************************************
  // observed signals and capture vector
  // ************************************************************
  // capture values and chain registers
  logic [PORT_W-1:0]    cap_id;
  logic [PORT_W-1:0]    cap_od;
  logic [PORT_W-1:0]    cap_oc;
  logic                 cpu_reset;
  logic [CHAIN_LEN-1:0] cap_vec;
  logic [CHAIN_LEN-1:0] shift_r;
  logic [CHAIN_LEN-1:0] shift_nxt;
  logic [CHAIN_LEN-1:0] upd_r;
  logic [CHAIN_LEN-1:0] upd_nxt;
  logic                 tdo_r;
  logic                 tdo_nxt;

  // internal processor reset, not the reset pin
  assign cpu_reset = (!RST_SRC.cpu_reset_request_n && RST_SRC.cpu_reset_enable)
                   || !RST_SRC.general_reset_n || RST_SRC.power_on_reset
                   || RST_SRC.config_download;

  // port group capture, pin level read past the alternate functions
  assign cap_id = tap_s.mode ? pin_s2_r : PIN_INPUT_REGISTER;
  assign cap_od = PORT_OUTPUT_REGISTER;
  assign cap_oc = DATA_DIRECTION_BIT;

  // pack the chain; no rc oscillator cell exists
  genvar g;
  generate
    for (g = 0; g < PORT_W; g++) begin : g_cap
      assign cap_vec[CELL_PORT0 + g*CELLS_PER_PIN + PIN_ID] = cap_id[g];
      assign cap_vec[CELL_PORT0 + g*CELLS_PER_PIN + PIN_OD] = cap_od[g];
      assign cap_vec[CELL_PORT0 + g*CELLS_PER_PIN + PIN_OC] = cap_oc[g];
    end
  endgenerate
  // single cells: reset, two-wire pads and oscillators
  assign cap_vec[CELL_RST]   = cpu_reset;
  assign cap_vec[CELL_SCLOE] = SCL_FUNC_OE;
  assign cap_vec[CELL_SCLIN] = scl_in_s;
  assign cap_vec[CELL_SDAOE] = SDA_FUNC_OE;
  assign cap_vec[CELL_SDAIN] = sda_in_s;
  assign cap_vec[CELL_XOEN]  = XTAL_EN_FUNC;
  assign cap_vec[CELL_XOUT]  = xtal_clk_s;
  assign cap_vec[CELL_TOEN]  = TOSC_EN_FUNC;
  assign cap_vec[CELL_TOUT]  = tosc_clk_s;

  // ************************************************************
  // shift and update stages
  // ************************************************************
  // capture or shift on rising test clock, update and tdo on falling
  always_comb begin
    shift_nxt = shift_r;
    upd_nxt   = upd_r;
    tdo_nxt   = tdo_r;
    if (tck_rise && tap_s.capture) begin
      shift_nxt = cap_vec;
    end else if (tck_rise && tap_s.shift) begin
      shift_nxt = {tap_s.tdi, shift_r[CHAIN_LEN-1:1]};
    end
    if (tck_fall) begin
      tdo_nxt = shift_r[0];
      if (tap_s.update) begin
        upd_nxt = shift_r;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      shift_r <= '0;
      upd_r   <= '0;
      tdo_r   <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      upd_r   <= upd_nxt;
      tdo_r   <= tdo_nxt;
    end
  end

  // ************************************************************
  // pin drive
  // ************************************************************
  // update views and registered pad controls
  logic [PORT_W-1:0] u_od;
  logic [PORT_W-1:0] u_oc;
  logic [PORT_W-1:0] pin_out_nxt;
  logic [PORT_W-1:0] pin_oe_nxt;
  logic [PORT_W-1:0] pld_nxt;
  logic [6:0]        misc_r;
  logic [6:0]        misc_nxt;
  logic [PORT_W-1:0] pin_out_r;
  logic [PORT_W-1:0] pin_oe_r;
  logic [PORT_W-1:0] pld_r;

  // per-pin update cells that drive the pad
  generate
    for (g = 0; g < PORT_W; g++) begin : g_upd
      assign u_od[g] = upd_r[CELL_PORT0 + g*CELLS_PER_PIN + PIN_OD];
      assign u_oc[g] = upd_r[CELL_PORT0 + g*CELLS_PER_PIN + PIN_OC];
    end
  endgenerate

  // test mode takes update cells, else function; observe cells drive nothing
  always_comb begin
    pin_out_nxt = tap_s.mode ? u_od : FUNC_OUT;
    pin_oe_nxt  = tap_s.mode ? u_oc : (FUNC_OE | DATA_DIRECTION_BIT);
    pld_nxt     = tap_s.mode ? (u_oc | ~u_od)
                             : (DATA_DIRECTION_BIT | ~PORT_OUTPUT_REGISTER);
    misc_nxt[0] = tap_s.mode ? upd_r[CELL_SCLOE] : SCL_FUNC_OE;
    misc_nxt[1] = tap_s.mode ? upd_r[CELL_SDAOE] : SDA_FUNC_OE;
    misc_nxt[2] = tap_s.mode ? upd_r[CELL_XOEN]  : XTAL_EN_FUNC;
    misc_nxt[3] = tap_s.mode ? upd_r[CELL_TOEN]  : TOSC_EN_FUNC;
    misc_nxt[4] = cpu_reset;
    misc_nxt[5] = tdo_r;
    misc_nxt[6] = 1'b0;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pin_out_r <= '0;
      pin_oe_r  <= '0;
      pld_r     <= '0;
      misc_r    <= '0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
      pld_r     <= pld_nxt;
      misc_r    <= misc_nxt;
    end
  end

  // port pad controls
  assign PIN_OUT        = pin_out_r;
  assign PIN_OE         = pin_oe_r;
  assign PULLUP_DISABLE = pld_r;

  // two-wire pads pull low only
  assign SCL_OUT        = misc_r[6]; // open drain, only ever low
  assign SDA_OUT        = misc_r[6];
  assign SCL_OE         = misc_r[0];
  assign SDA_OE         = misc_r[1];

  // oscillator enables
  assign XTAL_EN        = misc_r[2];
  assign TOSC_EN        = misc_r[3];

  // observed reset and serial out
  assign CPU_RESET_OBS  = misc_r[4];
  assign TDO            = misc_r[5];

endmodule : pbs_scan_cells
`default_nettype wire

// file: dv/pbs_scan_cells_sva.sv
// assertion checker for the pin boundary-scan cells
`timescale 1ns/1ps
`default_nettype none
module pbs_scan_cells_sva
  import pbs_pkg::*;
(
  input wire logic              CLK_SYS,
  input wire logic              RST,
  input wire logic              TCK,
  input wire pbs_tap_t          TAP,
  input wire pbs_rst_src_t      RST_SRC,
  input wire logic              CPU_RESET_OBS,
  input wire logic [PORT_W-1:0] PORT_OUTPUT_REGISTER,
  input wire logic [PORT_W-1:0] DATA_DIRECTION_BIT,
  input wire logic [PORT_W-1:0] FUNC_OE,
  input wire logic [PORT_W-1:0] PIN_OUT,
  input wire logic [PORT_W-1:0] PIN_OE,
  input wire logic [PORT_W-1:0] PULLUP_DISABLE,
  input wire logic              SCL_FUNC_OE,
  input wire logic              SDA_FUNC_OE,
  input wire logic              SCL_OUT,
  input wire logic              SCL_OE,
  input wire logic              SDA_OUT,
  input wire logic              SDA_OE,
  input wire logic              XTAL_EN_FUNC,
  input wire logic              XTAL_EN,
  input wire logic              TOSC_EN_FUNC,
  input wire logic              TOSC_EN
);
  // any reset source active
  logic rq;
  assign rq = (!RST_SRC.cpu_reset_request_n && RST_SRC.cpu_reset_enable)
    || !RST_SRC.general_reset_n || RST_SRC.power_on_reset || RST_SRC.config_download;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  rst_set_a:
    assert property (rq |=> CPU_RESET_OBS) else $error("reset not observed");
  rst_clear_a:
    assert property (!rq |=> !CPU_RESET_OBS) else $error("reset seen without source");
  pullup_func_a:
    assert property (!TAP.mode [*4] |=> PULLUP_DISABLE ==
      ($past(DATA_DIRECTION_BIT) | ~$past(PORT_OUTPUT_REGISTER))) else $error("pullup wrong");
  pin_oe_func_a:
    assert property (!TAP.mode [*4] |=> PIN_OE == ($past(FUNC_OE) | $past(DATA_DIRECTION_BIT)))
      else $error("pin enable wrong");
  twi_low_a:
    assert property (!SCL_OUT && !SDA_OUT) else $error("two-wire pin driven high");
  drive_func_a:
    assert property (!TAP.mode [*4] |=> {SCL_OE, SDA_OE, XTAL_EN, TOSC_EN} ==
      $past({SCL_FUNC_OE, SDA_FUNC_OE, XTAL_EN_FUNC, TOSC_EN_FUNC})) else $error("enable wrong");
  test_hold_a:
    assert property ((TCK && TAP.mode) [*8] |=> $stable(PIN_OE) && $stable(SCL_OE)
      && $stable(SDA_OE) && $stable(XTAL_EN) && $stable(TOSC_EN)) else $error("cell moved");
  pullup_test_a:
    assert property (TAP.mode [*8] |=> PULLUP_DISABLE == (PIN_OE | ~PIN_OUT))
      else $error("test pullup wrong");
endmodule : pbs_scan_cells_sva
bind pbs_scan_cells pbs_scan_cells_sva i_sva (
  .CLK_SYS, .RST, .TCK, .TAP, .RST_SRC, .CPU_RESET_OBS, .PORT_OUTPUT_REGISTER,
  .DATA_DIRECTION_BIT, .FUNC_OE, .PIN_OUT, .PIN_OE, .PULLUP_DISABLE, .SCL_FUNC_OE,
  .SDA_FUNC_OE, .SCL_OUT, .SCL_OE, .SDA_OUT, .SDA_OE, .XTAL_EN_FUNC, .XTAL_EN,
  .TOSC_EN_FUNC, .TOSC_EN);
`default_nettype wire

// file: dv/pbs_tester.sv
// boundary-scan tester model driving the test port
`timescale 1ns/1ps
`default_nettype none
module pbs_tester
  import pbs_pkg::*;
#(
  parameter int HALF = 8
)(
  input  wire logic CLK_SYS,
  input  wire logic TDO,
  output logic      TCK,
  output pbs_tap_t  TAP
);
  // test clock stands low between frames
  initial begin
    TCK = 1'b0;
    TAP = '0;
  end
  // one test clock, controls set mid low phase, tdo taken just before rise
  task automatic pulse(input logic [2:0] ctl, input logic d, output logic o);
    repeat (HALF / 2) @(posedge CLK_SYS);
    #1 TAP = {TAP.mode, ctl, d};
    repeat (HALF / 2) @(posedge CLK_SYS);
    #1 o = TDO;
    TCK = 1'b1;
    repeat (HALF) @(posedge CLK_SYS);
    #1 TCK = 1'b0;
  endtask : pulse
  // capture, shift the whole chain, update
  task automatic scan(input logic m, input logic [CHAIN_LEN-1:0] din,
                      output logic [CHAIN_LEN-1:0] dout);
    logic o;
    TAP.mode = m;
    pulse(3'b100, 1'b0, o);
    for (int i = 0; i < CHAIN_LEN; i++) pulse(3'b010, din[i], dout[i]);
    pulse(3'b001, 1'b0, o);
  endtask : scan
endmodule : pbs_tester
`default_nettype wire

// file: dv/pin_boundary_scan_cells_tb.sv
// self-checking bench for the pin boundary-scan cells
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module pin_boundary_scan_cells_tb
  import pbs_pkg::*;
;
  logic                 clk_sys, rst, tck, tdo, cpu_obs, scl_in, sda_in, scl_ext, sda_ext;
  logic                 scl_foe, sda_foe, scl_out, scl_oe, sda_out, sda_oe;
  logic                 xen_f, xclk, xen, ten_f, tclk, ten;
  logic [PORT_W-1:0]    pin_in, port_out, ddr, pin_lvl, func_out, func_oe, pin_out, pin_oe, pud;
  logic [PORT_W-1:0]    e_od, e_oc;
  logic [CHAIN_LEN-1:0] pat, q;
  pbs_tap_t             tap;
  pbs_rst_src_t         rsrc;
  int                   fail_count = 0;
  int                   tests_run = 0;
  // open-drain pins with pull-up, low if any party pulls
  assign scl_in = scl_ext && !scl_oe;
  assign sda_in = sda_ext && !sda_oe;
  pbs_tester i_tester (.CLK_SYS(clk_sys), .TDO(tdo), .TCK(tck), .TAP(tap));
  pbs_scan_cells i_dut (
    .CLK_SYS(clk_sys), .RST(rst), .TCK(tck), .TAP(tap), .TDO(tdo), .RST_SRC(rsrc),
    .CPU_RESET_OBS(cpu_obs), .PIN_INPUT_REGISTER(pin_in), .PORT_OUTPUT_REGISTER(port_out),
    .DATA_DIRECTION_BIT(ddr), .PIN_LEVEL(pin_lvl), .FUNC_OUT(func_out), .FUNC_OE(func_oe),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULLUP_DISABLE(pud), .SCL_IN(scl_in),
    .SDA_IN(sda_in), .SCL_FUNC_OE(scl_foe), .SDA_FUNC_OE(sda_foe), .SCL_OUT(scl_out),
    .SCL_OE(scl_oe), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .XTAL_EN_FUNC(xen_f),
    .XTAL_CLK(xclk), .XTAL_EN(xen), .TOSC_EN_FUNC(ten_f), .TOSC_CLK(tclk), .TOSC_EN(ten));
  // expected observed reset from the sources
  function automatic logic rexp(input pbs_rst_src_t s);
    return (!s.cpu_reset_request_n && s.cpu_reset_enable) || !s.general_reset_n
      || s.power_on_reset || s.config_download;
  endfunction : rexp
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    report_and_stop();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    rsrc = 5'b10100;
    {pin_in, port_out, ddr, pin_lvl, func_out, func_oe} = 48'hC30F_5A3C_6681;
    {scl_ext, sda_ext, scl_foe, sda_foe, xen_f, ten_f, xclk, tclk} = 8'b1110_1010;
    repeat (10) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 `CHK("pullup", ddr | ~port_out, pud)
    `CHK("pin_oe", func_oe | ddr, pin_oe)
    `CHK("twi_oe", {scl_foe, sda_foe}, {scl_oe, sda_oe})
    `CHK("osc_en", {xen_f, ten_f}, {xen, ten})
    `CHK("pin_out_f", func_out, pin_out)
    `CHK("twi_out", 2'h0, {scl_out, sda_out})
    for (int i = 0; i < 32; i++) begin
      rsrc = i[4:0];
      repeat (2) @(posedge clk_sys);
      #1 `CHK("cpu_rst", rexp(rsrc), cpu_obs)
    end
    pat = 33'h0_AAAA_AAAA;
    i_tester.scan(1'b0, pat, q);
    `CHK("obs", {tclk, xclk, sda_in, scl_in, 1'b1}, {q[8], q[6], q[4], q[2], q[0]})
    `CHK("gen_cap", {ten_f, xen_f, sda_foe, scl_foe}, {q[7], q[5], q[3], q[1]})
    for (int g = 0; g < PORT_W; g++) begin
      `CHK("id_norm", pin_in[g], q[CELL_PORT0 + CELLS_PER_PIN * g + PIN_ID])
      `CHK("od_norm", port_out[g], q[CELL_PORT0 + CELLS_PER_PIN * g + PIN_OD])
      `CHK("oc_norm", ddr[g], q[CELL_PORT0 + CELLS_PER_PIN * g + PIN_OC])
    end
    rsrc = 5'b10100;
    i_tester.scan(1'b1, ~pat, q);
    `CHK("twi_pull", 2'b00, {q[4], q[2]})
    for (int g = 0; g < PORT_W; g++) `CHK("id_test", pin_lvl[g], q[CELL_PORT0 + 3 * g])
    pat = ~pat;
    for (int g = 0; g < PORT_W; g++) begin
      e_od[g] = pat[CELL_PORT0 + CELLS_PER_PIN * g + PIN_OD];
      e_oc[g] = pat[CELL_PORT0 + CELLS_PER_PIN * g + PIN_OC];
    end
    repeat (8) @(posedge clk_sys);
    #1 `CHK("pin_out", e_od, pin_out)
    `CHK("pin_oe_t", e_oc, pin_oe)
    `CHK("pullup_t", e_oc | ~e_od, pud)
    `CHK("scan_en", {pat[1], pat[3], pat[5], pat[7]}, {scl_oe, sda_oe, xen, ten})
    `CHK("obs_free", 1'b0, cpu_obs)
    report_and_stop();
  end
endmodule : pin_boundary_scan_cells_tb
`default_nettype wire
